// ### design/acc_pkg.sv
// package: register map, fields, encodings and timing counts for the converter
package acc_pkg;
  // register byte addresses
  localparam logic [11:0] OFF_SC1  = 12'h000;
  localparam logic [11:0] OFF_CFG  = 12'h004;
  localparam logic [11:0] OFF_RH   = 12'h008;
  localparam logic [11:0] OFF_RL   = 12'h00C;
  localparam logic [11:0] OFF_CVH  = 12'h010;
  localparam logic [11:0] OFF_CVL  = 12'h014;
  localparam logic [11:0] OFF_PD1  = 12'h018;
  localparam logic [11:0] OFF_PD2  = 12'h01C;
  localparam logic [11:0] OFF_PD3  = 12'h020;
  localparam logic [11:0] OFF_SC2  = 12'h024;
  // status_control_one fields
  localparam int SC1_CONVERSION_COMPLETE_FLAG = 7;
  localparam int SC1_CONVERSION_IRQ_ENABLE = 6;
  localparam int SC1_CONT = 5;
  localparam int SC1_CH_HI = 4;
  // sc2 fields
  localparam int SC2_ACT  = 7;
  localparam int SC2_TRG  = 6;
  localparam int SC2_COMPARE_ENABLE = 5;
  localparam int SC2_ACFGT = 4;
  // configuration fields
  localparam int CFG_DIV_LO = 5;
  localparam int CFG_MODE_LO = 2;
  localparam int CFG_CLK_LO = 0;
  // reset values
  localparam logic [4:0] CH_OFF     = 5'h1F;
  localparam logic [7:0] PD_RESET   = 8'h00;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  // encodings
  localparam logic [1:0] CLK_BUS    = 2'h0;
  localparam logic [1:0] CLK_BUS2   = 2'h1;
  localparam logic [1:0] CLK_ALT    = 2'h2;
  localparam logic [1:0] CLK_ASYNC  = 2'h3;
  localparam logic [1:0] MODE_8     = 2'h0;
  localparam logic [1:0] MODE_12    = 2'h1;
  localparam logic [1:0] MODE_10    = 2'h2;
  // timing: conversion length in converter clocks, and input synchronizer depth in flops
  localparam logic [5:0] SAMPLE_CK  = 6'h04;
  localparam logic [3:0] BITS_FULL  = 4'hC;
  localparam logic [3:0] BITS_8     = 4'h9;
  localparam logic [2:0] SYNC_DEPTH = 3'h3;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b100
  } acc_state_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } acc_apb_rsp_t;

  typedef struct packed {
    logic [7:0] sc1;
    logic [7:0] sc2;
    logic [7:0] cfg;
    logic [7:0] cvh;
    logic [7:0] cvl;
    logic [7:0] rh;
    logic [7:0] rl;
    logic [7:0] pd1;
    logic [7:0] pd2;
    logic [7:0] pd3;
  } acc_regs_t;
endpackage

// ### design/acc_top.sv
// converter control: registers, clock divide, triggers, sequencing, results
// Notes on behaviour
// - mid pin register: bit n disables port control of channel n+8
// - high pin register: bit 7..0 for channels 23..16; zero keeps port
// - disabled pin: driver off, input and pullup off, port read zero
// - converter disabled in reset and while channel select is all ones
// - after a finished conversion with nothing pending, sit idle
// - approximation gives 12 bits in 12/10-bit mode, 9 bits in 8-bit
// - 10-bit rounds across both result registers; 8-bit rounds into low
// - result written sets complete flag; irq only if enable set then
// - compare runs whenever compare enable is set, in every mode
// - four clock sources selectable; bus clock after reset
// - halved bus clock then divider gives up to divide by sixteen
// - internal async clock keeps running in wait and stop3
// - divide field gives one, two, four or eight
// - trigger enable set: rising edge of trigger input starts conversion
// - trigger edge during a conversion is ignored
// - continuous hardware mode: only the first edge counts
// - software mode: write to status one with live channel starts
// - continuous mode restarts after each transfer until aborted
// - high read without low read blocks transfer in 12/10-bit mode (not 8-bit), no flag, result lost
// - single with compare false: blocking moot, conversion stops
// - other blocked transfers start another conversion
// - clock select codes: bus, bus/2, alternate, internal async
// - divide codes 00..11 give 1, 2, 4, 8
// - mode codes: 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
module acc_top
  import acc_pkg::*;
#(
  parameter int unsigned NPIN = 24
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              alt_clk_i,
  input  wire logic              async_clk_i,
  input  wire logic              hw_trigger_input_i,
  input  wire logic              cmp_bit_i,
  output logic                   conv_irq_o,
  output logic                   async_clk_run_o,
  output logic                   conv_busy_o,
  output logic                   sample_o,
  output logic      [4:0]        chan_o,
  output logic      [11:0]       trial_o,
  output logic      [NPIN-1:0]   pin_analog_o
);
  if (NPIN != 24) begin : g_npin_check
    $error("acc_top supports exactly 24 pins");
  end

  typedef struct packed {
    acc_regs_t     r;
    acc_state_t    st;
    logic [3:0]    bitn;
    logic [5:0]    samp;
    logic [11:0]   sar;
    logic [3:0]    div;
    logic [2:0]    syn_alt;
    logic [2:0]    syn_async;
    logic [2:0]    syn_trg;
    logic          trg_lvl;
    logic          alt_lvl;
    logic          async_lvl;
    logic          rh_lock;
    logic          cont_armed;
    logic          irq;
    logic          busy;
    logic          in_sample;
    logic          async_run;
    acc_apb_rsp_t  rsp;
  } acc_st_t;

  acc_st_t q;
  acc_st_t d;

  logic        acc_w;
  logic        acc_r;
  logic [7:0]  wb;
  logic        live;
  logic        ck_src;
  logic        ck_tick;
  logic [3:0]  div_max;
  logic [3:0]  ck_lim;
  logic [3:0]  bit_lo;
  logic [11:0] sar_fin;
  logic [12:0] rnd;
  logic [11:0] res;
  logic [12:0] diff;
  logic [11:0] cv;
  logic        cmp_ok;
  logic        trg_rise;
  logic        done;
  logic        restart;
  logic        do_start;
  logic        cfg_wr;

  always_comb begin
    d = q;
    acc_w = psel_i && penable_i && pwrite_i && !q.rsp.pready;
    acc_r = psel_i && penable_i && !pwrite_i && !q.rsp.pready;
    wb = pwdata_i[7:0];
    d.rsp.pready = psel_i && penable_i && !q.rsp.pready;
    d.rsp.pslverr = 1'b0;
    d.rsp.prdata = 32'h0000_0000;
    live = q.r.sc1[SC1_CH_HI:0] != CH_OFF;
    // level inputs cross on three flops; second and third must agree
    d.syn_alt = {q.syn_alt[1:0], alt_clk_i};
    d.syn_async = {q.syn_async[1:0], async_clk_i};
    d.syn_trg = {q.syn_trg[1:0], hw_trigger_input_i};
    if (q.syn_alt[2] == q.syn_alt[1]) d.alt_lvl = q.syn_alt[2];
    if (q.syn_async[2] == q.syn_async[1]) d.async_lvl = q.syn_async[2];
    if (q.syn_trg[2] == q.syn_trg[1]) d.trg_lvl = q.syn_trg[2];
    trg_rise = (q.syn_trg[2] == q.syn_trg[1]) && q.syn_trg[2] && !q.trg_lvl;
    // source pick, then the programmable divider
    unique case (q.r.cfg[CFG_CLK_LO+:2])
      CLK_BUS:  ck_src = 1'b1;
      CLK_BUS2: ck_src = 1'b1;
      CLK_ALT:  ck_src = d.alt_lvl && !q.alt_lvl;
      CLK_ASYNC: ck_src = d.async_lvl && !q.async_lvl;
    endcase
    unique case (q.r.cfg[CFG_DIV_LO+:2])
      2'h0: div_max = 4'h0;
      2'h1: div_max = 4'h1;
      2'h2: div_max = 4'h3;
      2'h3: div_max = 4'h7;
    endcase
    // halving folded into the count: twice the divider, up to sixteen
    ck_lim = div_max;
    if (q.r.cfg[CFG_CLK_LO+:2] == CLK_BUS2)
      ck_lim = {div_max[2:0], 1'b1};
    ck_tick = 1'b0;
    if (ck_src) begin
      ck_tick = q.div >= ck_lim;
      d.div = ck_tick ? 4'h0 : q.div + 4'h1;
    end
    // 8-bit mode runs the top nine trial bits so the trial keeps full scale
    bit_lo = 4'h0;
    if (q.r.cfg[CFG_MODE_LO+:2] == MODE_8)
      bit_lo = BITS_FULL - BITS_8;
    // last trial decision folds in before the result is shaped
    sar_fin = q.sar;
    if (!cmp_bit_i)
      sar_fin[q.bitn] = 1'b0;
    // result shaping
    unique case (q.r.cfg[CFG_MODE_LO+:2])
      MODE_10: begin
        rnd = {1'b0, sar_fin} + 13'h0002;
        res = rnd[12] ? 12'h3FF : {2'h0, rnd[11:2]};
      end
      MODE_8: begin
        rnd = {4'h0, sar_fin[11:3]} + 13'h0001;
        res = rnd[9] ? 12'h0FF : {4'h0, rnd[8:1]};
      end
      default: begin
        rnd = {1'b0, sar_fin};
        res = sar_fin;
      end
    endcase
    cv = {q.r.cvh[3:0], q.r.cvl};
    if (q.r.cfg[CFG_MODE_LO+:2] == MODE_8) cv = {4'h0, q.r.cvl};
    diff = {1'b0, res} - {1'b0, cv};
    cmp_ok = !q.r.sc2[SC2_COMPARE_ENABLE] ||
             (q.r.sc2[SC2_ACFGT] ? !diff[12] : diff[12]);
    done = (q.st == ST_CONV) && ck_tick && (q.bitn == bit_lo);
    restart = 1'b0;
    d.irq = 1'b0;
    // sequencer
    unique case (q.st)
      ST_IDLE: ;
      ST_SAMPLE: if (ck_tick) begin
        d.samp = q.samp - 6'h01;
        if (q.samp == 6'h01) begin
          d.st = ST_CONV;
          d.bitn = BITS_FULL - 4'h1;
          d.sar = 12'h000;
          d.sar[d.bitn] = 1'b1;
        end
      end
      ST_CONV: if (ck_tick) begin
        d.sar = sar_fin;
        if (q.bitn != bit_lo) begin
          d.bitn = q.bitn - 4'h1;
          d.sar[q.bitn - 4'h1] = 1'b1;
        end
      end
    endcase
    if (done) begin
      d.st = ST_IDLE;
      if (!cmp_ok && !q.r.sc1[SC1_CONT]) begin
        restart = 1'b0;
      end else if (q.rh_lock && q.r.cfg[CFG_MODE_LO+:2] != MODE_8) begin
        restart = 1'b1;
      end else begin
        if (cmp_ok) begin
          d.r.rh = {4'h0, (q.r.sc2[SC2_COMPARE_ENABLE] ? diff[11:8] : res[11:8])};
          d.r.rl = q.r.sc2[SC2_COMPARE_ENABLE] ? diff[7:0] : res[7:0];
          d.r.sc1[SC1_CONVERSION_COMPLETE_FLAG] = 1'b1;
          d.irq = q.r.sc1[SC1_CONVERSION_IRQ_ENABLE];
        end
        restart = q.r.sc1[SC1_CONT];
      end
    end
    do_start = restart;
    if (trg_rise && q.r.sc2[SC2_TRG] && q.st == ST_IDLE && !done &&
        !q.cont_armed) begin
      do_start = 1'b1;
      d.cont_armed = q.r.sc1[SC1_CONT];
    end
    // register writes; any config write aborts the conversion
    cfg_wr = 1'b0;
    if (acc_w) begin
      unique case (paddr_i)
        OFF_SC1: begin
          d.r.sc1 = {1'b0, wb[6:0]};
          d.cont_armed = 1'b0;
          d.st = ST_IDLE;
          do_start = !q.r.sc2[SC2_TRG] && (wb[4:0] != CH_OFF);
        end
        OFF_SC2: begin
          d.r.sc2 = {1'b0, wb[6:0]};
          cfg_wr = 1'b1;
        end
        OFF_CFG: begin
          d.r.cfg = wb;
          cfg_wr = 1'b1;
        end
        OFF_CVH: begin
          d.r.cvh = wb;
          cfg_wr = 1'b1;
        end
        OFF_CVL: begin
          d.r.cvl = wb;
          cfg_wr = 1'b1;
        end
        OFF_PD1: d.r.pd1 = wb;
        OFF_PD2: d.r.pd2 = wb;
        OFF_PD3: d.r.pd3 = wb;
        OFF_RH, OFF_RL: ;
        default: d.rsp.pslverr = 1'b1;
      endcase
    end
    if (cfg_wr) begin
      d.st = ST_IDLE;
      d.cont_armed = 1'b0;
      do_start = 1'b0;
    end
    if (do_start &&
        (acc_w && paddr_i == OFF_SC1 ? wb[4:0] != CH_OFF : live)) begin
      d.st = ST_SAMPLE;
      d.samp = SAMPLE_CK;
    end
    if (acc_r) begin
      unique case (paddr_i)
        OFF_SC1: d.rsp.prdata[7:0] = q.r.sc1;
        OFF_SC2: d.rsp.prdata[7:0] = {q.st != ST_IDLE, q.r.sc2[6:0]};
        OFF_CFG: d.rsp.prdata[7:0] = q.r.cfg;
        OFF_CVH: d.rsp.prdata[7:0] = q.r.cvh;
        OFF_CVL: d.rsp.prdata[7:0] = q.r.cvl;
        OFF_RH: begin
          d.rsp.prdata[7:0] = q.r.rh;
          d.rh_lock = q.r.cfg[CFG_MODE_LO+:2] != MODE_8;
        end
        OFF_RL: begin
          d.rsp.prdata[7:0] = q.r.rl;
          d.rh_lock = 1'b0;
          if (!(done && d.r.sc1[SC1_CONVERSION_COMPLETE_FLAG] && !q.r.sc1[SC1_CONVERSION_COMPLETE_FLAG]))
            d.r.sc1[SC1_CONVERSION_COMPLETE_FLAG] = 1'b0;
        end
        OFF_PD1: d.rsp.prdata[7:0] = q.r.pd1;
        OFF_PD2: d.rsp.prdata[7:0] = q.r.pd2;
        OFF_PD3: d.rsp.prdata[7:0] = q.r.pd3;
        default: d.rsp.pslverr = 1'b1;
      endcase
    end
    if (!live && !(acc_w && paddr_i == OFF_SC1)) d.st = ST_IDLE;
    // status outputs kept in flops, in step with the state they mirror
    d.busy = d.st != ST_IDLE;
    d.in_sample = d.st == ST_SAMPLE;
    d.async_run = d.r.cfg[CFG_CLK_LO+:2] == CLK_ASYNC;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.r.sc1 <= {3'h0, CH_OFF};
      q.r.cfg <= CFG_RESET;
      q.r.pd1 <= PD_RESET;
      q.r.pd2 <= PD_RESET;
      q.r.pd3 <= PD_RESET;
    end else begin
      q <= d;
    end
  end

  assign prdata_o = q.rsp.prdata;
  assign pready_o = q.rsp.pready;
  assign pslverr_o = q.rsp.pslverr;
  assign conv_irq_o = q.irq;
  assign async_clk_run_o = q.async_run;
  assign conv_busy_o = q.busy;
  assign sample_o = q.in_sample;
  assign chan_o = q.r.sc1[SC1_CH_HI:0];
  assign trial_o = q.sar;
  // pin pad control: high forces driver off, input and pullup off, read zero
  assign pin_analog_o = {q.r.pd3, q.r.pd2, q.r.pd1};
endmodule

// ### verif/acc_checker.sv
// checker: port properties of the converter control
`timescale 1ns/1ps
module acc_checker
  import acc_pkg::*;
#(
  parameter int unsigned NPIN = 24
) (
  input wire logic            clk_i,
  input wire logic            rstn_i,
  input wire logic            psel_i,
  input wire logic            penable_i,
  input wire logic            pwrite_i,
  input wire logic            pready_o,
  input wire logic            pslverr_o,
  input wire logic            conv_irq_o,
  input wire logic            conv_busy_o,
  input wire logic            sample_o,
  input wire logic            async_clk_run_o,
  input wire logic [4:0]      chan_o,
  input wire logic [NPIN-1:0] pin_analog_o
);
  logic wr_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // write strobe one cycle late, so a changed output can name its cause
  always_ff @(posedge clk_i)
    wr_q <= psel_i && penable_i && pwrite_i && !pready_o;
  sequence s_taken;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_answer;
    pready_o ##1 !pready_o;
  endsequence
  chk_apb_answer: assert property (s_taken |=> s_answer)
    else $error("ready not a single cycle after access");
  sequence s_start;
    $rose(conv_busy_o);
  endsequence
  chk_start_sample: assert property (s_start |-> sample_o)
    else $error("conversion began without a sample phase");
  chk_sample_busy: assert property (sample_o |-> conv_busy_o)
    else $error("sample phase while idle");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  chk_irq_pulse: assert property (conv_irq_o |=> !conv_irq_o)
    else $error("interrupt longer than one cycle");
  chk_reset_clears: assert property (disable iff (1'b0)
    !rstn_i |=> !conv_busy_o && !conv_irq_o && chan_o == CH_OFF
    && pin_analog_o == '0) else $error("outputs not cleared by reset");
  chk_off_idle: assert property (chan_o == CH_OFF |-> !conv_busy_o)
    else $error("busy with channel off");
  // reset edges also move these, so the cycle after reset is left out
  chk_pins_write: assert property ($changed(pin_analog_o) &&
    $past(rstn_i) |-> wr_q) else $error("pins moved without a write");
  chk_chan_write: assert property ($changed(chan_o) &&
    $past(rstn_i) |-> wr_q) else $error("channel moved without a write");
  chk_clk_write: assert property ($changed(async_clk_run_o) &&
    $past(rstn_i) |-> wr_q) else $error("clock enable moved alone");
endmodule

bind acc_top acc_checker #(.NPIN(NPIN)) acc_checker_inst (.clk_i, .rstn_i,
  .psel_i, .penable_i, .pwrite_i, .pready_o, .pslverr_o, .conv_irq_o,
  .conv_busy_o, .sample_o, .async_clk_run_o, .chan_o, .pin_analog_o);

// ### verif/acc_analog_model.sv
// model: analog input, comparator and the two far-side clock sources
`timescale 1ns/1ps
module acc_analog_model (
  input  wire logic        clk_i,
  input  wire logic [11:0] vin_i,
  input  wire logic [11:0] trial_i,
  input  wire logic        run_i,
  output logic             cmp_o,
  output logic             alt_o,
  output logic             async_o
);
  logic [3:0] ticks = 4'h0;
  always @(posedge clk_i)
    ticks <= ticks + 4'h1;
  // ideal comparator: keep the trial bit while it is not above the input
  assign cmp_o = trial_i <= vin_i;
  assign alt_o = ticks[1];
  // internal source stands low unless the converter enables it
  assign async_o = run_i & ticks[2];
endmodule

// ### verif/acc_top_tb.sv
// testbench: register-level tests of the converter control
`timescale 1ns/1ps
module acc_top_tb
  import acc_pkg::*;
;
  logic        clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0;
  logic        penable_i = 1'b0, pwrite_i = 1'b0, hw_trigger_input_i = 1'b0;
  logic [11:0] paddr_i = 12'h000, vin = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic        pready_o, pslverr_o, conv_irq_o, async_clk_run_o, e;
  logic        conv_busy_o, sample_o, alt_clk_i, async_clk_i, cmp_bit_i;
  logic [4:0]  chan_o;
  logic [11:0] trial_o;
  logic [23:0] pin_analog_o;
  logic [7:0]  q;
  int          num_errors = 0, num_checks = 0, irqs = 0, n, i0, f;

  acc_top #(.NPIN(24)) acc_top_inst (.clk_i, .rstn_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .alt_clk_i, .async_clk_i, .hw_trigger_input_i, .cmp_bit_i, .conv_irq_o,
    .async_clk_run_o, .conv_busy_o, .sample_o, .chan_o, .trial_o,
    .pin_analog_o);
  acc_analog_model acc_analog_model_inst (.clk_i, .vin_i(vin),
    .trial_i(trial_o), .run_i(async_clk_run_o), .cmp_o(cmp_bit_i),
    .alt_o(alt_clk_i), .async_o(async_clk_i));

  always #12.5 clk_i = ~clk_i;
  always @(negedge clk_i)
    if (conv_irq_o === 1'b1)
      irqs++;

  task automatic test_done;
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    test_done;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held up to the rising edge that samples ready high; data is
  // taken at that edge; an idle cycle keeps strobes from colliding
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int t;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (pready_o !== 1'b1 && t < 20);
    if (t >= 20)
      hang;
    q = prdata_o[7:0];
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(q, x);
  endtask
  task automatic run(input logic [7:0] c, input logic [7:0] s);
    wr(OFF_CFG, c);
    wr(OFF_SC1, s);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (conv_busy_o === 1'b1 && n < 2000);
    if (n >= 2000)
      hang;
    repeat (3) @(posedge clk_i);
  endtask
  // polls status only, never the results, while a conversion runs
  task automatic wait_flag;
    for (int t = 0; t <= 400; t++) begin
      if (t == 400)
        hang;
      apb(1'b0, OFF_SC1, 8'h00);
      if (q[SC1_CONVERSION_COMPLETE_FLAG] === 1'b1)
        break;
    end
  endtask
  task automatic pulse;
    hw_trigger_input_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    hw_trigger_input_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rc(OFF_PD2, PD_RESET);
    rc(OFF_PD3, PD_RESET);
    rc(OFF_CFG, CFG_RESET);
    rc(OFF_SC1, {3'h0, CH_OFF});
    wr(OFF_PD2, 8'hA5);
    wr(OFF_PD3, 8'h3C);
    rc(OFF_PD2, 8'hA5);
    rc(OFF_PD3, 8'h3C);
    chk(pin_analog_o, 24'h3CA500);
    apb(1'b0, 12'h030, 8'h00);
    chk(e, 1'b1);
    vin <= 12'hABC;
    for (int k = 0; k < 16; k++) begin
      f = 1 << (k / 4 + k % 4);
      run({1'b0, k[1:0], 1'b0, MODE_12, k[3:2]}, 8'h03);
      chk(async_clk_run_o, k / 4 == 3);
      chk(n >= 15 * f - 4 && n <= 17 * f + 8, 1'b1);
      rc(OFF_SC1, 8'h83);
      rc(OFF_RH, 8'h0A);
      rc(OFF_RL, 8'hBC);
      chk(trial_o, 12'hABC);
    end
    chk(irqs, 0);
    vin <= 12'hABF;
    run({4'h0, MODE_10, CLK_BUS}, 8'h43);
    chk(irqs, 1);
    rc(OFF_RH, 8'h02);
    rc(OFF_RL, 8'hB0);
    vin <= 12'h5C9;
    run({4'h0, MODE_8, CLK_BUS}, 8'h03);
    rc(OFF_RL, 8'h5D);
    rc(OFF_RH, 8'h00);
    chk(trial_o, 12'h5C8);
    vin <= 12'h123;
    wr(OFF_CFG, {4'h0, MODE_12, CLK_BUS});
    wr(OFF_SC1, 8'h63);
    wait_flag;
    rc(OFF_RH, 8'h01);
    i0 = irqs;
    vin <= 12'h456;
    repeat (120) @(posedge clk_i);
    chk(irqs, i0);
    rc(OFF_RL, 8'h23);
    wait_flag;
    rc(OFF_RH, 8'h04);
    rc(OFF_RL, 8'h56);
    wr(OFF_SC1, {3'h0, CH_OFF});
    repeat (3) @(posedge clk_i);
    chk(conv_busy_o, 1'b0);
    wr(OFF_SC2, 8'h40);
    wr(OFF_SC1, 8'h43);
    repeat (3) @(posedge clk_i);
    chk(conv_busy_o, 1'b0);
    i0 = irqs;
    pulse;
    chk(conv_busy_o, 1'b1);
    pulse;
    repeat (60) @(posedge clk_i);
    chk(irqs, i0 + 1);
    wr(OFF_CVH, 8'h04);
    wr(OFF_CVL, 8'h00);
    wr(OFF_SC2, 8'h30);
    vin <= 12'h456;
    run({4'h0, MODE_12, CLK_BUS}, 8'h03);
    rc(OFF_SC1, 8'h83);
    rc(OFF_RL, 8'h56);
    vin <= 12'h123;
    run({4'h0, MODE_12, CLK_BUS}, 8'h03);
    rc(OFF_SC1, 8'h03);
    rc(OFF_RL, 8'h56);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    chk(pin_analog_o, 24'h0);
    rc(OFF_CFG, CFG_RESET);
    test_done;
  end
endmodule
